// >>> core/software_supervisor_watchdog.sv
// Operation
// R01: rc clock through divider taps sets interval
// R02: enabled timeout sets the watchdog interrupt flag
// R03: reset follows timeout unless interrupt serviced first
// R04: default interval is two to twelfth
// R05: reset exactly 512 rc cycles after timeout
// R06: any reset restores default period select
// R07: two period select bits lengthen interval
// R08: early period change clears watchdog count
// R09: software must write control before expiry
// R10: selects give 2^12, 2^15, 2^18, 2^21
// R11: separate enables gate interrupt and reset
`timescale 1ns/100ps
`default_nettype none

module software_supervisor_watchdog #(
  parameter int BASE_SHIFT = wdog_pkg::BASE_SHIFT, // log2 of shortest interval
  parameter int SHIFT_STEP = wdog_pkg::SHIFT_STEP, // log2 step per select value
  parameter int RESET_DELAY = wdog_pkg::RESET_DELAY, // rc cycles to the reset
  parameter int COUNT_WIDTH = wdog_pkg::COUNT_WIDTH // interval counter width
) (
  input wire logic clock, // system clock, 50 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic rc_osc_clock, // internal rc oscillator, asynchronous
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic irq, // level interrupt, high while unmasked flag set
  output logic wdog_reset // system reset request, held until rst
);

  // watchdog phases
  typedef enum logic [1:0] {
    WD_COUNTING,
    WD_COUNTDOWN,
    WD_RESETTING
  } wd_state_t;

  localparam int DW = wdog_pkg::DELAY_WIDTH; // countdown counter width

  // countdown terminal value, the last rc tick before the reset
  localparam logic [DW-1:0] DELAY_LAST = DW'(RESET_DELAY - 1);

  // terminal count of the interval for a period select value
  function automatic logic [COUNT_WIDTH-1:0] interval_last(input logic [1:0] psel);
    int shift;
    shift = BASE_SHIFT + SHIFT_STEP * int'(psel);
    return COUNT_WIDTH'((64'd1 << shift) - 64'd1);
  endfunction

  // one if a bus address matches a register offset
  function automatic logic addr_is(input logic [7:0] adr, input logic [7:0] offset);
    return {adr[7:2], 2'b00} == offset;
  endfunction

  // control and state registers
  logic irq_en; // interrupt enable
  logic rst_en; // reset enable
  logic [1:0] period_select_field; // interval select
  logic [wdog_pkg::STAT_WIDTH-1:0] status; // sticky event flags
  logic [wdog_pkg::STAT_WIDTH-1:0] mask; // interrupt mask
  logic [COUNT_WIDTH-1:0] wd_count; // interval counter in rc ticks
  logic [DW-1:0] delay_count; // countdown counter in rc ticks
  wd_state_t state; // current phase
  wd_state_t next_state; // phase for the next cycle

  // tick and bus decode wires
  wire rc_tick; // one pulse per rc oscillator cycle
  wire bus_req; // an access is pending and not yet answered
  wire wr_req; // write access this cycle
  wire rd_req; // read access this cycle
  wire sel_ctrl; // control register addressed
  wire sel_status; // status register addressed
  wire sel_mask; // mask register addressed
  wire sel_count; // count register addressed
  wire sel_state; // state register addressed
  wire lane0_wr; // write touches the low byte
  wire ctrl_wr; // control register write
  wire mask_wr; // mask register write
  wire status_rd; // status read, clears flags
  wire [1:0] wr_psel; // period select carried by a control write
  wire restart_wr; // software service write
  wire psel_change; // period select really changes
  wire early_change; // change made while counting, no countdown running
  wire interval_done; // last tick of the selected interval
  wire timeout_evt; // interval timeout this cycle
  wire delay_done; // last tick of the countdown
  wire serviced; // interrupt condition cleared by software
  wire [wdog_pkg::STAT_WIDTH-1:0] status_set; // events this cycle
  wire [wdog_pkg::STAT_WIDTH-1:0] next_status; // status after set and clear
  wire [31:0] ctrl_view; // control register as read
  wire [31:0] state_view; // state register as read
  logic [31:0] next_rdata; // selected read data

  // rising edges of the rc oscillator become ticks [R01]
  rc_tick_sync #(
    .STAGES(wdog_pkg::SYNC_STAGES)
  ) u_rc_tick (
    .clock(clock),
    .rst(rst),
    .rc_osc_clock(rc_osc_clock),
    .rc_tick(rc_tick)
  );

  // wishbone decode; ack comes one cycle after the strobe
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_req = bus_req & wb_we_i;
  assign rd_req = bus_req & ~wb_we_i;
  assign sel_ctrl = addr_is(wb_adr_i, wdog_pkg::CTRL_OFFSET);
  assign sel_status = addr_is(wb_adr_i, wdog_pkg::STATUS_OFFSET);
  assign sel_mask = addr_is(wb_adr_i, wdog_pkg::MASK_OFFSET);
  assign sel_count = addr_is(wb_adr_i, wdog_pkg::COUNT_OFFSET);
  assign sel_state = addr_is(wb_adr_i, wdog_pkg::STATE_OFFSET);
  assign lane0_wr = wr_req & wb_sel_i[0];
  assign ctrl_wr = lane0_wr & sel_ctrl;
  assign mask_wr = lane0_wr & sel_mask;
  assign status_rd = rd_req & sel_status;

  // fields of a control write
  assign wr_psel = wb_dat_i[wdog_pkg::CTRL_PSEL_MSB:wdog_pkg::CTRL_PSEL_LSB]; // [R07]
  assign restart_wr = ctrl_wr & wb_dat_i[wdog_pkg::CTRL_RESTART_BIT]; // [R09]
  assign psel_change = ctrl_wr & (wr_psel != period_select_field);

  // a period change only restarts the count while no countdown runs
  assign early_change = psel_change & (state == WD_COUNTING); // [R08]

  // interval end at the selected divider tap [R01] [R10]
  assign interval_done = rc_tick & (wd_count == interval_last(period_select_field));
  assign timeout_evt = interval_done & (state == WD_COUNTING) & ~early_change & ~restart_wr;

  // countdown end, exactly RESET_DELAY ticks after the timeout [R05]
  assign delay_done = rc_tick & (delay_count == DELAY_LAST);

  // service: restart write, or the flag read away while it was set [R03]
  assign serviced = restart_wr | (status_rd & status[wdog_pkg::STAT_TIMEOUT_BIT]);

  // the timeout flag only sets while the interrupt is enabled [R02] [R11]
  assign status_set = {{(wdog_pkg::STAT_WIDTH-1){1'b0}}, timeout_evt & irq_en};

  // a read clears the flags, but an event in the same cycle survives
  assign next_status = (status & ~({wdog_pkg::STAT_WIDTH{status_rd}})) | status_set;

  // read views
  assign ctrl_view = {28'h0000000, period_select_field, rst_en, irq_en};
  assign state_view = {30'h00000000, state == WD_RESETTING, state == WD_COUNTDOWN};

  // read data select; unmapped addresses read as zero
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (sel_ctrl)
    begin
      next_rdata = ctrl_view;
    end
    else if (sel_status)
    begin
      next_rdata = 32'(status);
    end
    else if (sel_mask)
    begin
      next_rdata = 32'(mask);
    end
    else if (sel_count)
    begin
      next_rdata = 32'(wd_count);
    end
    else if (sel_state)
    begin
      next_rdata = state_view;
    end
  end

  // phase sequencing of the watchdog
  always_comb
  begin
    next_state = state;
    case (state)
      WD_COUNTING:
      begin
        // interval expired: start the reset countdown [R03]
        if (timeout_evt)
        begin
          next_state = WD_COUNTDOWN;
        end
      end
      WD_COUNTDOWN:
      begin
        // service before the countdown ends cancels the reset [R03]
        if (serviced)
        begin
          next_state = WD_COUNTING;
        end
        else if (delay_done & rst_en)
        begin
          next_state = WD_RESETTING; // [R11]
        end
        else if (delay_done)
        begin
          next_state = WD_COUNTING; // reset disabled, start over
        end
      end
      WD_RESETTING:
      begin
        // held until the system reset brings the block back
        next_state = WD_RESETTING;
      end
      default:
      begin
        next_state = WD_COUNTING;
      end
    endcase
  end

  // bus handshake and read data
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_req ? next_rdata : 32'h00000000;
    end
  end

  // control register; every reset returns the default selection [R06] [R04]
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irq_en <= wdog_pkg::CTRL_IRQ_EN_RESET;
      rst_en <= wdog_pkg::CTRL_RST_EN_RESET;
      period_select_field <= wdog_pkg::PSEL_RESET; // [R06]
    end
    else if (ctrl_wr)
    begin
      irq_en <= wb_dat_i[wdog_pkg::CTRL_IRQ_EN_BIT]; // [R11]
      rst_en <= wb_dat_i[wdog_pkg::CTRL_RST_EN_BIT]; // [R11]
      period_select_field <= wr_psel; // [R07]
    end
  end

  // mask register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mask <= wdog_pkg::MASK_RESET;
    end
    else if (mask_wr)
    begin
      mask <= wb_dat_i[wdog_pkg::STAT_WIDTH-1:0];
    end
  end

  // sticky status flags
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      status <= '0;
    end
    else
    begin
      status <= next_status; // [R02]
    end
  end

  // interval counter: cleared by a restart write, early change and timeout
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wd_count <= '0;
    end
    else if (restart_wr | early_change | timeout_evt)
    begin
      wd_count <= '0; // [R08] [R09]
    end
    else if (rc_tick & (state == WD_COUNTING))
    begin
      wd_count <= wd_count + COUNT_WIDTH'(1); // [R01]
    end
  end

  // reset countdown counter, runs only between timeout and reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      delay_count <= '0;
    end
    else if (state != WD_COUNTDOWN)
    begin
      delay_count <= '0;
    end
    else if (rc_tick)
    begin
      delay_count <= delay_count + DW'(1); // [R05]
    end
  end

  // phase register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= WD_COUNTING;
    end
    else
    begin
      state <= next_state;
    end
  end

  // interrupt and reset outputs, both straight from flops
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irq <= 1'b0;
      wdog_reset <= 1'b0;
    end
    else
    begin
      irq <= |(next_status & mask);
      wdog_reset <= (next_state == WD_RESETTING); // [R03] [R11]
    end
  end

endmodule

`default_nettype wire

// >>> include/wdog_pkg.sv
// shared constants for the software supervisor watchdog
package wdog_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] CTRL_OFFSET = 8'h00; // supervisor_control_reg
  localparam logic [7:0] STATUS_OFFSET = 8'h04; // sticky event flags, read clears
  localparam logic [7:0] MASK_OFFSET = 8'h08; // interrupt mask, same layout as status
  localparam logic [7:0] COUNT_OFFSET = 8'h0C; // live interval count, read only
  localparam logic [7:0] STATE_OFFSET = 8'h10; // reset countdown state, read only

  // control register field positions
  localparam int CTRL_IRQ_EN_BIT = 0; // lets a timeout set the flag
  localparam int CTRL_RST_EN_BIT = 1; // lets the countdown drive the reset
  localparam int CTRL_PSEL_LSB = 2; // period_select_bit0
  localparam int CTRL_PSEL_MSB = 3; // period_select_bit1
  localparam int CTRL_RESTART_BIT = 4; // write one to restart, reads zero

  // status and mask field positions
  localparam int STAT_TIMEOUT_BIT = 0; // wdog_timeout_irq_flag
  localparam int STAT_WIDTH = 1; // number of event bits

  // reset values
  localparam logic CTRL_IRQ_EN_RESET = 1'b1; // interrupt enabled after reset
  localparam logic CTRL_RST_EN_RESET = 1'b1; // reset output enabled after reset
  localparam logic [1:0] PSEL_RESET = 2'h0; // shortest interval
  localparam logic [STAT_WIDTH-1:0] MASK_RESET = 1'h0; // all events masked

  // interval and countdown timing, in rc oscillator cycles
  localparam int BASE_SHIFT = 12; // divide by two to the twelfth at select 00
  localparam int SHIFT_STEP = 3; // each select step adds three powers of two
  localparam int COUNT_WIDTH = 21; // enough for the longest interval
  localparam int RESET_DELAY = 512; // rc cycles from timeout to reset
  localparam int DELAY_WIDTH = 10; // holds the countdown value

  // synchroniser depth for the rc oscillator pin
  localparam int SYNC_STAGES = 2;

endpackage

// >>> core/rc_tick_sync.sv
`timescale 1ns/100ps
`default_nettype none

// brings the free running rc oscillator into the system clock domain and
// turns each rising edge of it into a one cycle tick
module rc_tick_sync #(
  parameter int STAGES = wdog_pkg::SYNC_STAGES
) (
  input wire logic clock, // system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic rc_osc_clock, // rc oscillator pin, asynchronous
  output logic rc_tick // one cycle pulse per rc rising edge
);

  logic [STAGES-1:0] sync_chain; // synchroniser, bit 0 is the first stage
  logic rc_seen; // last synchronised level, for edge detection
  wire rc_level; // synchronised level

  assign rc_level = sync_chain[STAGES-1];

  // only the later stages are read by logic, never the first flop
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync_chain <= '0;
      rc_seen <= 1'b0;
      rc_tick <= 1'b0;
    end
    else
    begin
      sync_chain <= {sync_chain[STAGES-2:0], rc_osc_clock};
      rc_seen <= rc_level;
      rc_tick <= rc_level & ~rc_seen;
    end
  end

endmodule

`default_nettype wire

// >>> bench/wdog_checker.sv
`timescale 1ns/100ps
`default_nettype none

module wdog_checker (
  input wire logic clock, // system clock
  input wire logic rst, // async reset
  input wire logic rc_osc_clock, // rc pin
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic irq, // interrupt
  input wire logic wdog_reset // reset request
);
  logic rc_q; // rc pin seen last clock
  logic [3:0] since_rc; // clocks since rc rise, saturating
  wire rc_rise = rc_osc_clock && !rc_q; // rc rising edge seen
  wire stat_rd = wb_ack_o && !wb_we_i && (wb_adr_i[7:2] == wdog_pkg::STATUS_OFFSET[7:2]);

  // age of the last rc edge, so the reset moment can be tied to a tick
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rc_q <= 1'b0;
      since_rc <= 4'hF;
    end
    else
    begin
      rc_q <= rc_osc_clock;
      if (rc_rise)
        since_rc <= 4'h0;
      else if (since_rc != 4'hF)
        since_rc <= since_rc + 4'h1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data nonzero outside ack");
  AST_RST_HOLD: assert property (wdog_reset |=> wdog_reset)
    else $error("reset request dropped");
  AST_RST_TICK: assert property ($rose(wdog_reset) |-> since_rc inside {[1:7]})
    else $error("reset request not tied to an rc tick");
  AST_IRQ_HOLD: assert property (irq && !wb_cyc_i |=> irq)
    else $error("irq dropped without access");
  AST_READ_CLR: assert property (stat_rd && wb_dat_o[0] |=> !irq)
    else $error("irq still high after status read");
  AST_START_QUIET: assert property ($fell(rst) |-> !irq && !wdog_reset)
    else $error("outputs active after reset");

  cover property ($rose(irq));
  cover property ($rose(wdog_reset));
  cover property (stat_rd && wb_dat_o[0]);
endmodule

bind software_supervisor_watchdog wdog_checker i_wdog_checker (.clock(clock), .rst(rst),
  .rc_osc_clock(rc_osc_clock), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq(irq), .wdog_reset(wdog_reset));

`default_nettype wire

// >>> bench/software_supervisor_watchdog_tb.sv
`timescale 1ns/100ps
`default_nettype none

module software_supervisor_watchdog_tb;
  localparam int BSH = 4; // short base interval
  localparam int STP = 1; // short select step
  localparam int DLY = 8; // short reset delay
  logic clock, rst, rc_osc_clock, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, wdog_reset;
  logic [7:0] wb_adr_i; // address
  logic [3:0] wb_sel_i; // lanes
  logic [31:0] wb_dat_i, wb_dat_o, rd, rnd; // data
  int n_errors, num_checks, cycles, rc_edges, seed, t0, dt, i;

  software_supervisor_watchdog #(.BASE_SHIFT(BSH), .SHIFT_STEP(STP), .RESET_DELAY(DLY))
    i_software_supervisor_watchdog (.clock(clock), .rst(rst), .rc_osc_clock(rc_osc_clock),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq(irq), .wdog_reset(wdog_reset));

  always #10 clock = ~clock;
  // rc edges fall on multiples of 100 ns, never on a rising clock edge
  always #100 rc_osc_clock = ~rc_osc_clock;
  always @(posedge rc_osc_clock) rc_edges++;

  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_errors++;
      complete_run;
    end
  end

  // control word from its fields
  function automatic logic [31:0] ctrl(input logic ie, re, input logic [1:0] ps, input logic rs);
    logic [31:0] v;
    v = 32'h0;
    v[wdog_pkg::CTRL_IRQ_EN_BIT] = ie;
    v[wdog_pkg::CTRL_RST_EN_BIT] = re;
    v[wdog_pkg::CTRL_PSEL_MSB:wdog_pkg::CTRL_PSEL_LSB] = ps;
    v[wdog_pkg::CTRL_RESTART_BIT] = rs;
    return v;
  endfunction

  // rc ticks in the interval of a select value
  function automatic int ticks(input int sel);
    return 1 << (BSH + STP * sel);
  endfunction

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task chk_rng(input string name, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    chk("ack", 1'b1, wb_ack_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(name, exp, rd);
  endtask

  // waits for irq (0) or reset request (1), giving rc edges since t0
  task wait_hi(input logic which);
    int n;
    n = 0;
    while ((which ? wdog_reset : irq) !== 1'b1 && n < 4000)
    begin
      @(posedge clock);
      n++;
    end
    dt = rc_edges - t0;
    t0 = rc_edges;
  endtask

  task pulse_reset;
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
  endtask

  task complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    {clock, rc_osc_clock, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
    {n_errors, num_checks, cycles, rc_edges} = 128'h0;
    seed = 32'h4328;
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rdchk("ctrl", wdog_pkg::CTRL_OFFSET, ctrl(1, 1, 0, 0));
    rdchk("unmapped", 8'h14, 32'h0);
    wb(1'b1, wdog_pkg::MASK_OFFSET, 32'h1, 4'hF);
    // every select value, each serviced by a status read
    for (i = 0; i < 4; i++)
    begin
      wb(1'b1, wdog_pkg::CTRL_OFFSET, ctrl(1, 1, i[1:0], 1), 4'hF);
      t0 = rc_edges;
      wait_hi(1'b0);
      chk_rng("interval", ticks(i) - 1, ticks(i) + 1, dt);
      rdchk("flag", wdog_pkg::STATUS_OFFSET, 32'h1); // service read
      // longer than the countdown, shorter than the next interval
      repeat (100) @(posedge clock);
      chk("serviced", 1'b0, wdog_reset);
    end
    // select change mid-count restarts the count
    wb(1'b1, wdog_pkg::CTRL_OFFSET, ctrl(1, 1, 2, 1), 4'hF);
    t0 = rc_edges;
    wait (rc_edges == t0 + 40);
    wb(1'b1, wdog_pkg::CTRL_OFFSET, ctrl(1, 1, 1, 0), 4'hF);
    t0 = rc_edges;
    wb(1'b0, wdog_pkg::COUNT_OFFSET, 32'h0, 4'hF);
    chk_rng("count cleared", 0, 1, rd);
    wait_hi(1'b0);
    chk_rng("after change", ticks(1) - 1, ticks(1) + 1, dt);
    rdchk("countdown", wdog_pkg::STATE_OFFSET, 32'h1);
    wait_hi(1'b1);
    chk_rng("reset delay", DLY - 1, DLY + 1, dt);
    rdchk("resetting", wdog_pkg::STATE_OFFSET, 32'h2);
    pulse_reset;
    rdchk("ctrl again", wdog_pkg::CTRL_OFFSET, ctrl(1, 1, 0, 0));
    rdchk("state idle", wdog_pkg::STATE_OFFSET, 32'h0);
    // both enables off: no flag and no reset
    wb(1'b1, wdog_pkg::CTRL_OFFSET, ctrl(0, 0, 0, 1), 4'hF);
    t0 = rc_edges;
    wait (rc_edges == t0 + 60);
    rdchk("no flag", wdog_pkg::STATUS_OFFSET, 32'h0);
    chk("no reset", 1'b0, wdog_reset);
    // random writes off the map and without lane 0 leave control alone
    for (i = 0; i < 8; i++)
    begin
      rnd = $random(seed);
      wb(1'b1, {1'b1, rnd[6:2], 2'h0}, rnd, 4'hF);
      wb(1'b1, wdog_pkg::CTRL_OFFSET, rnd, {rnd[3:1], 1'b0});
      rdchk("ctrl kept", wdog_pkg::CTRL_OFFSET, ctrl(0, 0, 0, 0));
    end
    complete_run;
  end
endmodule

`default_nettype wire
